/* verilog/mdp_data_port.sv */
// phy side mii data port: clocks, tx capture, rx drive, crs and col
`timescale 1ns/100ps
module mdp_data_port (
  // clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_srst,
  // link control
  input  wire mdp_pkg::mdp_speed_t         i_speed,
  input  wire logic                        i_full_duplex,
  // mii transmit pins (from mac)
  output logic                             o_tx_clk,
  input  wire logic                        i_tx_en,
  input  wire logic [mdp_pkg::NIB_W-1:0]   i_txd,
  // mii receive pins (to mac)
  output logic                             o_rx_clk,
  output logic [mdp_pkg::NIB_W-1:0]        o_rxd,
  output logic                             o_rx_dv,
  output logic                             o_rx_er,
  output logic                             o_crs,
  output logic                             o_col,
  // transmit stream to line coder
  output logic [mdp_pkg::NIB_W-1:0]        o_line_txd,
  output logic                             o_line_tx_vld,
  // receive stream from line decoder, one nibble per rx clock
  input  wire logic                        i_line_carrier,
  input  wire logic                        i_line_rx_vld,
  input  wire logic [mdp_pkg::NIB_W-1:0]   i_line_rxd,
  input  wire logic                        i_line_rx_err,
  input  wire logic                        i_line_collision
);
  import mdp_pkg::*;

  logic mii_clk;
  logic rise_en;
  logic fall_en;

  // one divider serves both mii clocks so tx and rx stay in phase
  mdp_clk_gen u_clk_gen (
    .i_mclk    (i_mclk),
    .i_srst    (i_srst),
    .i_speed   (i_speed),
    .o_mii_clk (mii_clk),
    .o_rise_en (rise_en),
    .o_fall_en (fall_en)
  );

  assign o_tx_clk = mii_clk;
  assign o_rx_clk = mii_clk;

  // transmit pins come from the mac domain: two flops each
  logic             tx_en_s1_r;
  logic             tx_en_s2_r;
  logic [NIB_W-1:0] txd_s1_r;
  logic [NIB_W-1:0] txd_s2_r;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_en_s1_r <= 1'b0;
      tx_en_s2_r <= 1'b0;
      txd_s1_r   <= NIB_RST;
      txd_s2_r   <= NIB_RST;
    end else begin
      tx_en_s1_r <= i_tx_en;
      tx_en_s2_r <= tx_en_s1_r;
      txd_s1_r   <= i_txd;
      txd_s2_r   <= txd_s1_r;
    end
  end

  // sample the mac nibble at rising tx clock; sync delay is two system cycles, at most half a half period
  logic [NIB_W-1:0] ltxd_r;
  logic [NIB_W-1:0] ltxd_nxt;
  logic             ltx_vld_r;
  logic             ltx_vld_nxt;

  always_comb begin
    ltxd_nxt    = ltxd_r;
    ltx_vld_nxt = ltx_vld_r;
    if (rise_en) begin
      ltxd_nxt    = txd_s2_r;
      ltx_vld_nxt = tx_en_s2_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ltxd_r    <= NIB_RST;
      ltx_vld_r <= 1'b0;
    end else begin
      ltxd_r    <= ltxd_nxt;
      ltx_vld_r <= ltx_vld_nxt;
    end
  end

  assign o_line_txd    = ltxd_r;
  assign o_line_tx_vld = ltx_vld_r;

  // receive: outputs change on the falling rx clock so the mac samples stable data at rise
  mdp_rx_state_t    rx_st_r;
  mdp_rx_state_t    rx_st_nxt;
  logic [NIB_W-1:0] rxd_r;
  logic [NIB_W-1:0] rxd_nxt;
  logic             rx_dv_r;
  logic             rx_dv_nxt;
  logic             rx_er_r;
  logic             rx_er_nxt;
  logic             rx_crs_r;
  logic             rx_crs_nxt;

  always_comb begin
    rx_st_nxt  = rx_st_r;
    rxd_nxt    = rxd_r;
    rx_dv_nxt  = rx_dv_r;
    rx_er_nxt  = rx_er_r;
    rx_crs_nxt = rx_crs_r;
    // carrier rises at once, independent of the rx clock
    if (i_line_carrier) begin
      rx_crs_nxt = 1'b1;
    end
    if (fall_en) begin
      rxd_nxt   = i_line_rx_vld ? i_line_rxd : NIB_RST;
      rx_dv_nxt = i_line_rx_vld;
      rx_er_nxt = i_line_rx_err;
      case (rx_st_r)
        MDP_RX_IDLE: begin
          if (i_line_carrier) begin
            rx_st_nxt = MDP_RX_FRAME;
          end else begin
            // a carrier blip between two rx clock edges must not leave crs stuck high
            rx_crs_nxt = 1'b0;
          end
        end
        MDP_RX_FRAME: begin
          if (!i_line_carrier) begin
            rx_st_nxt = MDP_RX_DRAIN;
          end
        end
        MDP_RX_DRAIN: begin
          // loss of carrier: drop crs on a clock edge only
          rx_crs_nxt = i_line_carrier;
          rx_st_nxt  = i_line_carrier ? MDP_RX_FRAME : MDP_RX_IDLE;
        end
        default: begin
          rx_st_nxt  = MDP_RX_IDLE;
          rx_crs_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_st_r  <= MDP_RX_IDLE;
      rxd_r    <= NIB_RST;
      rx_dv_r  <= 1'b0;
      rx_er_r  <= 1'b0;
      rx_crs_r <= 1'b0;
    end else begin
      rx_st_r  <= rx_st_nxt;
      rxd_r    <= rxd_nxt;
      rx_dv_r  <= rx_dv_nxt;
      rx_er_r  <= rx_er_nxt;
      rx_crs_r <= rx_crs_nxt;
    end
  end

  assign o_rxd   = rxd_r;
  assign o_rx_dv = rx_dv_r;
  assign o_rx_er = rx_er_r;

  // carrier sense and collision, registered on the system clock, not on an mii clock
  logic crs_r;
  logic crs_nxt;
  logic col_r;
  logic col_nxt;

  always_comb begin
    if (i_full_duplex) begin
      crs_nxt = rx_crs_nxt;
      col_nxt = 1'b0;
    end else begin
      // own transmission falls with the tx enable, which the mac drives on tx clock
      crs_nxt = rx_crs_nxt | tx_en_s2_r;
      col_nxt = i_line_collision;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      crs_r <= 1'b0;
      col_r <= 1'b0;
    end else begin
      crs_r <= crs_nxt;
      col_r <= col_nxt;
    end
  end

  assign o_crs = crs_r;
  assign o_col = col_r;
endmodule : mdp_data_port

/* verilog/mdp_pkg.sv */
// package for the phy mii data port: constants and types
package mdp_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned MII_FAST_HZ     = 25_000_000;
  localparam int unsigned MII_SLOW_HZ     = 2_500_000;
  // half period of each mii clock in system cycles
  localparam int unsigned HALF_FAST_CYC   = CLK_HZ / (2 * MII_FAST_HZ);
  localparam int unsigned HALF_SLOW_CYC   = CLK_HZ / (2 * MII_SLOW_HZ);
  localparam int unsigned DIV_W           = 6;
  localparam logic [DIV_W-1:0] DIV_RST    = 6'h00;
  localparam int unsigned NIB_W           = 4;
  localparam logic [NIB_W-1:0] NIB_RST    = 4'h0;

  typedef enum logic {
    MDP_SPD_10,
    MDP_SPD_100
  } mdp_speed_t;

  typedef enum logic [1:0] {
    MDP_RX_IDLE,
    MDP_RX_FRAME,
    MDP_RX_DRAIN
  } mdp_rx_state_t;
endpackage : mdp_pkg

/* verilog/mdp_clk_gen.sv */
// mii clock generator: divides the system clock to 25 or 2.5 mhz
`timescale 1ns/100ps
module mdp_clk_gen (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_srst,
  // speed select
  input  wire mdp_pkg::mdp_speed_t i_speed,
  // generated clock and edge enables
  output logic                   o_mii_clk,
  output logic                   o_rise_en,
  output logic                   o_fall_en
);
  import mdp_pkg::*;

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             clk_r;
  logic             clk_nxt;
  logic [DIV_W-1:0] half_lim;
  logic             wrap;

  always_comb begin
    // speed change takes effect in the current half period, which ends at once if the count is past the new limit; no runt pulse
    half_lim = (i_speed == MDP_SPD_100) ? DIV_W'(HALF_FAST_CYC - 1) : DIV_W'(HALF_SLOW_CYC - 1);
    wrap     = (cnt_r >= half_lim);
    cnt_nxt  = wrap ? DIV_RST : cnt_r + 6'h01;
    clk_nxt  = wrap ? ~clk_r : clk_r;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_r <= DIV_RST;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign o_mii_clk = clk_r;
  assign o_rise_en = wrap & ~clk_r;
  assign o_fall_en = wrap & clk_r;
endmodule : mdp_clk_gen

/* sim/mdp_data_port_chk.sv */
// checker for the mii data port pins
`timescale 1ns/100ps
module mdp_data_port_chk (
  input wire logic i_mclk, i_srst, i_full_duplex, i_tx_en, i_line_carrier, i_line_collision,
  input wire mdp_pkg::mdp_speed_t i_speed,
  input wire logic o_tx_clk, o_rx_clk, o_rx_dv, o_rx_er, o_crs, o_col,
  input wire logic [mdp_pkg::NIB_W-1:0] o_rxd
);
  import mdp_pkg::*;
  logic [6:0] cnt_r;
  logic       seen_r;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // first toggle after reset is skipped, its phase is set by reset
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_r <= 7'h00;
      seen_r <= 1'b0;
    end else if ($changed(o_tx_clk)) begin
      cnt_r <= 7'h00;
      seen_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
  sequence s_tx_start;
    $rose(i_tx_en) && !i_full_duplex;
  endsequence
  a_clk_same: assert property (o_tx_clk == o_rx_clk) else $error("clocks differ");
  a_fast_half: assert property ($changed(o_tx_clk) && seen_r && i_speed == MDP_SPD_100 |->
    cnt_r == 7'(HALF_FAST_CYC - 1)) else $error("fast half period");
  a_slow_half: assert property ($changed(o_tx_clk) && seen_r && i_speed == MDP_SPD_10 |->
    cnt_r == 7'(HALF_SLOW_CYC - 1)) else $error("slow half period");
  a_rx_sync: assert property ($changed({o_rxd, o_rx_dv, o_rx_er}) |->
    !o_rx_clk && $past(o_rx_clk, 2)) else $error("rx change off clock");
  a_rxd_idle: assert property (!o_rx_dv |-> o_rxd == NIB_RST) else $error("rxd not idle");
  a_col_follow: assert property (!i_full_duplex |-> o_col == $past(i_line_collision))
    else $error("col wrong");
  a_col_fdx: assert property (i_full_duplex |-> !o_col) else $error("col in full duplex");
  a_crs_rise: assert property ($rose(i_line_carrier) |=> o_crs) else $error("crs late");
  a_crs_tx: assert property (s_tx_start |-> ##[1:4] o_crs) else $error("crs on tx");
  a_crs_sync: assert property (i_full_duplex && $fell(o_crs) |->
    !o_rx_clk && ($past(o_rx_clk, 2) || $past(o_rx_clk, 3))) else $error("crs fall off clock");
endmodule : mdp_data_port_chk
bind mdp_data_port mdp_data_port_chk mdp_data_port_chk_i (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_full_duplex(i_full_duplex), .i_tx_en(i_tx_en), .i_line_carrier(i_line_carrier),
  .i_line_collision(i_line_collision), .i_speed(i_speed), .o_tx_clk(o_tx_clk), .o_rx_clk(o_rx_clk),
  .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er), .o_crs(o_crs), .o_col(o_col), .o_rxd(o_rxd));

/* sim/mdp_mac_model.sv */
// mac model driving the transmit nibble stream
`timescale 1ns/100ps
module mdp_mac_model (
  input  wire logic                      i_tx_clk,
  output logic                           o_tx_en,
  output logic [mdp_pkg::NIB_W-1:0]      o_txd
);
  logic [mdp_pkg::NIB_W-1:0] nxt = 4'h0;
  int left = 0;
  int gap = 0;
  initial o_tx_en = 1'b0;
  initial o_txd = 4'h0;
  task automatic send(input logic [mdp_pkg::NIB_W-1:0] base, input int len, input int idle);
    nxt = base;
    gap = idle;
    left = len;
  endtask : send
  always @(posedge i_tx_clk) begin
    #1;
    if (gap == 0 && left > 0) begin
      o_tx_en = 1'b1;
      o_txd = nxt;
      nxt = nxt + 4'h1;
      left--;
    end else begin
      // released nibble keeps moving so a stale value is never mistaken for data
      gap = (gap > 0) ? gap - 1 : 0;
      o_tx_en = 1'b0;
      o_txd = ~o_txd;
    end
  end
endmodule : mdp_mac_model

/* sim/phy_mii_data_port_tb_top.sv */
// testbench for the phy mii data port
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module phy_mii_data_port_tb_top;
  import mdp_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, fdx = 1'b0, coll = 1'b0, rx_on = 1'b0, rx_req = 1'b0, rx_er = 1'b0;
  mdp_speed_t spd = MDP_SPD_100;
  logic car = 1'b0;
  logic tx_clk, rx_clk, tx_en, rx_dv, rx_er_o, crs, col, ltx_vld, exp_dv = 1'b0, exp_er = 1'b0;
  logic [NIB_W-1:0] txd, rxd = 4'h0, rxd_o, ltxd, exp_rxd = 4'h0, exp_tx;
  int miscompares = 0, num_checks = 0, cyc = 0, per;
  logic [NIB_W-1:0] txq[$];
  always #2.5 mclk = ~mclk;
  mdp_data_port mdp_data_port_i (.i_mclk(mclk), .i_srst(srst), .i_speed(spd), .i_full_duplex(fdx), .o_tx_clk(tx_clk),
    .i_tx_en(tx_en), .i_txd(txd), .o_rx_clk(rx_clk), .o_rxd(rxd_o), .o_rx_dv(rx_dv), .o_rx_er(rx_er_o), .o_crs(crs),
    .o_col(col), .o_line_txd(ltxd), .o_line_tx_vld(ltx_vld), .i_line_carrier(rx_on | car), .i_line_rx_vld(rx_on),
    .i_line_rxd(rxd), .i_line_rx_err(rx_er), .i_line_collision(coll));
  mdp_mac_model mdp_mac_model_i (.i_tx_clk(tx_clk), .o_tx_en(tx_en), .o_txd(txd));
  // last period's nibble is checked before the next one is driven
  always @(posedge rx_clk) begin
    `CHK({rx_dv, rx_er_o, rxd_o}, {exp_dv, exp_er, exp_rxd})
    #1;
    rx_on = rx_req;
    rxd = 4'($urandom);
    rx_er = rx_on & ($urandom % 5 == 0);
    exp_dv = rx_on;
    exp_er = rx_er;
    exp_rxd = rx_on ? rxd : 4'h0;
  end
  always @(negedge tx_clk) begin
    if (ltx_vld === 1'b1) begin
      exp_tx = txq.pop_front();
      `CHK(ltxd, exp_tx)
    end
  end
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic run(input mdp_speed_t s, input logic f, input int idle);
    logic [NIB_W-1:0] b;
    @(posedge mclk) #1;
    srst = 1'b1;
    spd = s;
    fdx = f;
    repeat (6) @(posedge mclk);
    #1 srst = 1'b0;
    per = (s == MDP_SPD_100) ? 2 * HALF_FAST_CYC : 2 * HALF_SLOW_CYC;
    b = 4'($urandom);
    for (int k = 0; k < 6; k++) txq.push_back(b + 4'(k));
    mdp_mac_model_i.send(b, 6, idle);
    repeat ((idle + 4) * per) @(posedge mclk);
    #1 `CHK(crs, ~f)
    rx_req = 1'b1;
    coll = 1'b1;
    repeat (per + 3) @(posedge mclk);
    #1 `CHK(col, ~f)
    `CHK(crs, 1'b1)
    coll = 1'b0;
    repeat (10 * per) @(posedge mclk);
    #1 rx_req = 1'b0;
    repeat (5 * per) @(posedge mclk);
    #1 `CHK(crs, 1'b0)
    // one-cycle carrier with no data: crs must rise and then fall on the rx clock
    car = 1'b1;
    @(posedge mclk) #1 car = 1'b0;
    `CHK(crs, 1'b1)
    repeat (3 * per + 2) @(posedge mclk);
    #1 `CHK(crs, 1'b0)
    `CHK(txq.size(), 0)
    $display("test speed %0d full duplex %0d done", s, f);
  endtask : run
  initial begin
    void'($urandom(21925));
    run(MDP_SPD_100, 1'b0, 0);
    run(MDP_SPD_100, 1'b1, 2);
    run(MDP_SPD_10, 1'b0, 1);
    run(MDP_SPD_10, 1'b1, 0);
    end_of_test();
  end
endmodule : phy_mii_data_port_tb_top
